/* File: verilog/mem_order_map.svh */
// named constants for the memory ordering and cache op broadcast block
// assumes inclusion by bare name from the package and the block
`ifndef MEM_ORDER_MAP_SVH
`define MEM_ORDER_MAP_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define MO_ADDR_W     32
`define MO_KIND_W     4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MO_RST_BIT    1'b0
`define MO_RST_READY  1'b1
`define MO_RST_ADDR   32'h0000_0000

`endif

/* File: verilog/mem_order_pkg.sv */
// types shared by the memory ordering and cache op broadcast block
// assumes mem_order_map.svh is on the include path
`include "mem_order_map.svh"

package mem_order_pkg;

  // ------------------------------------------------------------
  // operation kinds on request, local cache, bus and snoop ports
  // ------------------------------------------------------------
  typedef enum logic [`MO_KIND_W-1:0] {
    k_none,
    k_ci_access,
    k_eieio,
    k_isync,
    k_sync,
    k_icbi,
    k_dcbi,
    k_dcbf,
    k_dcbz,
    k_dcbst
  } op_kind_e;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_wait_ciwt,
    st_wait_older,
    st_isync,
    st_bus
  } seq_state_e;

endpackage

/* File: verilog/memory_ordering_cache_op_broadcast.sv */
// ordering barrier, refetch barrier and cache op broadcast sequencer
// assumes one request at a time from the load/store side, and a bus unit
// that acknowledges each broadcast with a one-cycle bus_ack
//
// Summary of operation
// - i/o barrier goes to load_store_unit, waits for earlier inhibited/write-through accesses
// - later inhibited/write-through accesses held until the i/o barrier executes
// - broadcast enable high: i/o barrier placed on external bus
// - i/o barrier bypasses l2, forwarded directly to bus unit
// - broadcast enable low: no i/o barrier transaction on the bus
// - noncacheable accesses always leave in program order
// - no store gathering across an i/o barrier in the store queue
// - refetch barrier flushes instruction queue, waits older instructions, then refetches
// - refetched instruction waits until older ones are past exception point
// - refetch barrier does not wait for pending stores
// - cache block ops act on local first and second level caches
// - zero op with coherence attribute is always broadcast
// - invalidate, flush, store ops broadcast only with broadcast enable
// - instruction invalidate op never placed on the bus
// - of snooped cache ops, only zero op draws a response
// - no other bus traffic from cache ops besides stated broadcasts
// - cache ops to direct-store segments are no-operations
// - with broadcast enable, full barrier completes after broadcast succeeds
`timescale 1ns/1ns
`include "mem_order_map.svh"

module memory_ordering_cache_op_broadcast #(
  parameter int ADDR_W = `MO_ADDR_W
) (
  // clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  // configuration from hw_impl_config_reg
  input  wire logic                      address_broadcast_enable,
  // operation request
  input  wire logic                      op_valid,
  input  wire mem_order_pkg::op_kind_e   op_kind,
  input  wire logic [ADDR_W-1:0]         op_addr,
  input  wire logic                      op_coh,
  input  wire logic                      op_seg_t,
  output logic                           op_ready_r,
  output logic                           op_done_r,
  output logic                           ci_issue_r,
  // core progress status
  input  wire logic                      ciwt_pending,
  input  wire logic                      older_busy,
  input  wire logic                      older_exc_window,
  // local cache operation
  output logic                           cache_op_valid_r,
  output mem_order_pkg::op_kind_e        cache_op_kind_r,
  output logic [ADDR_W-1:0]              cache_op_addr_r,
  // instruction fetch control
  output logic                           iq_flush_r,
  output logic                           refetch_r,
  // store queue control
  output logic                           sq_no_gather_r,
  // bus unit broadcast
  output logic                           bus_req_valid_r,
  output mem_order_pkg::op_kind_e        bus_req_kind_r,
  output logic [ADDR_W-1:0]              bus_req_addr_r,
  output logic                           bus_l2_bypass_r,
  input  wire logic                      bus_ack,
  // snoop from other masters
  input  wire logic                      snoop_valid,
  input  wire mem_order_pkg::op_kind_e   snoop_kind,
  input  wire logic [ADDR_W-1:0]         snoop_addr,
  output logic                           snoop_zero_r,
  output logic [ADDR_W-1:0]              snoop_zero_addr_r
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_cache_op(input mem_order_pkg::op_kind_e k);
    is_cache_op = (k == mem_order_pkg::k_icbi) || (k == mem_order_pkg::k_dcbi) ||
                  (k == mem_order_pkg::k_dcbf) || (k == mem_order_pkg::k_dcbz) ||
                  (k == mem_order_pkg::k_dcbst);
  endfunction

  // whether a local cache op goes out on the bus
  function automatic logic need_bcast(input mem_order_pkg::op_kind_e k, input logic coh, input logic en);
    case (k)
      mem_order_pkg::k_dcbz:  need_bcast = coh;
      mem_order_pkg::k_dcbi,
      mem_order_pkg::k_dcbf,
      mem_order_pkg::k_dcbst: need_bcast = en;
      default:                need_bcast = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mem_order_pkg::seq_state_e state_r, state_nxt;
  mem_order_pkg::op_kind_e   cur_kind_r, cur_kind_nxt;
  logic [ADDR_W-1:0]         cur_addr_r, cur_addr_nxt;
  logic                      bcast_en_s_r, bcast_en_s_nxt;
  logic                      op_ready_nxt, op_done_nxt, ci_issue_nxt;
  logic                      cache_op_valid_nxt, iq_flush_nxt, refetch_nxt;
  mem_order_pkg::op_kind_e   cache_op_kind_nxt, bus_req_kind_nxt;
  logic [ADDR_W-1:0]         cache_op_addr_nxt, bus_req_addr_nxt, snoop_zero_addr_nxt;
  logic                      sq_no_gather_nxt, bus_req_valid_nxt, bus_l2_bypass_nxt;
  logic                      snoop_zero_nxt;
  logic                      take;

  // requests only enter in idle, one at a time, so accesses keep program order
  assign take = op_valid && op_ready_r;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt           = state_r;
    cur_kind_nxt        = cur_kind_r;
    cur_addr_nxt        = cur_addr_r;
    bcast_en_s_nxt      = bcast_en_s_r;
    op_done_nxt         = `MO_RST_BIT;
    ci_issue_nxt        = `MO_RST_BIT;
    cache_op_valid_nxt  = `MO_RST_BIT;
    cache_op_kind_nxt   = cache_op_kind_r;
    cache_op_addr_nxt   = cache_op_addr_r;
    iq_flush_nxt        = `MO_RST_BIT;
    refetch_nxt         = `MO_RST_BIT;
    sq_no_gather_nxt    = sq_no_gather_r;
    bus_req_valid_nxt   = bus_req_valid_r;
    bus_req_kind_nxt    = bus_req_kind_r;
    bus_req_addr_nxt    = bus_req_addr_r;
    bus_l2_bypass_nxt   = bus_l2_bypass_r;
    snoop_zero_nxt      = `MO_RST_BIT;
    snoop_zero_addr_nxt = snoop_zero_addr_r;
    case (state_r)
      mem_order_pkg::st_idle: begin
        if (take) begin
          cur_kind_nxt = op_kind;
          cur_addr_nxt = op_addr;
          bcast_en_s_nxt = address_broadcast_enable;
          case (op_kind)
            mem_order_pkg::k_ci_access: begin
              // only reachable in idle, so never passes a pending barrier
              ci_issue_nxt = 1'b1;
              op_done_nxt  = 1'b1;
            end
            mem_order_pkg::k_eieio: begin
              sq_no_gather_nxt = 1'b1;
              state_nxt        = mem_order_pkg::st_wait_ciwt;
            end
            mem_order_pkg::k_sync: begin
              sq_no_gather_nxt = 1'b1;
              state_nxt        = mem_order_pkg::st_wait_older;
            end
            mem_order_pkg::k_isync: begin
              iq_flush_nxt = 1'b1;
              state_nxt    = mem_order_pkg::st_isync;
            end
            default: begin
              if (is_cache_op(op_kind) && !op_seg_t) begin
                cache_op_valid_nxt = 1'b1;
                cache_op_kind_nxt  = op_kind;
                cache_op_addr_nxt  = op_addr;
                if (need_bcast(op_kind, op_coh, address_broadcast_enable)) begin
                  bus_req_valid_nxt = 1'b1;
                  bus_req_kind_nxt  = op_kind;
                  bus_req_addr_nxt  = op_addr;
                  bus_l2_bypass_nxt = 1'b0;
                  state_nxt         = mem_order_pkg::st_bus;
                end else begin
                  op_done_nxt = 1'b1;
                end
              end else begin
                // direct-store segment or unknown kind: nothing happens
                op_done_nxt = 1'b1;
              end
            end
          endcase
        end
      end
      mem_order_pkg::st_wait_ciwt: begin
        if (!ciwt_pending) begin
          if (bcast_en_s_r) begin
            bus_req_valid_nxt = 1'b1;
            bus_req_kind_nxt  = cur_kind_r;
            bus_req_addr_nxt  = cur_addr_r;
            bus_l2_bypass_nxt = 1'b1;
            state_nxt         = mem_order_pkg::st_bus;
          end else begin
            sq_no_gather_nxt = 1'b0;
            op_done_nxt      = 1'b1;
            state_nxt        = mem_order_pkg::st_idle;
          end
        end
      end
      mem_order_pkg::st_wait_older: begin
        if (!older_busy && !ciwt_pending) begin
          if (bcast_en_s_r) begin
            bus_req_valid_nxt = 1'b1;
            bus_req_kind_nxt  = cur_kind_r;
            bus_req_addr_nxt  = cur_addr_r;
            bus_l2_bypass_nxt = 1'b0;
            state_nxt         = mem_order_pkg::st_bus;
          end else begin
            sq_no_gather_nxt = 1'b0;
            op_done_nxt      = 1'b1;
            state_nxt        = mem_order_pkg::st_idle;
          end
        end
      end
      mem_order_pkg::st_isync: begin
        // store queue state is deliberately not looked at here
        if (!older_busy && !older_exc_window) begin
          refetch_nxt = 1'b1;
          op_done_nxt = 1'b1;
          state_nxt   = mem_order_pkg::st_idle;
        end
      end
      mem_order_pkg::st_bus: begin
        if (bus_ack) begin
          bus_req_valid_nxt = 1'b0;
          bus_l2_bypass_nxt = 1'b0;
          sq_no_gather_nxt  = 1'b0;
          op_done_nxt       = 1'b1;
          state_nxt         = mem_order_pkg::st_idle;
        end
      end
      default: begin
        state_nxt = mem_order_pkg::st_idle;
      end
    endcase
    // snoop response: only the zero op, broadcast enable plays no part
    if (snoop_valid && snoop_kind == mem_order_pkg::k_dcbz) begin
      snoop_zero_nxt      = 1'b1;
      snoop_zero_addr_nxt = snoop_addr;
    end
    op_ready_nxt = (state_nxt == mem_order_pkg::st_idle);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r           <= mem_order_pkg::st_idle;
      cur_kind_r        <= mem_order_pkg::k_none;
      cur_addr_r        <= `MO_RST_ADDR;
      bcast_en_s_r      <= `MO_RST_BIT;
      op_ready_r        <= `MO_RST_READY;
      op_done_r         <= `MO_RST_BIT;
      ci_issue_r        <= `MO_RST_BIT;
      cache_op_valid_r  <= `MO_RST_BIT;
      cache_op_kind_r   <= mem_order_pkg::k_none;
      cache_op_addr_r   <= `MO_RST_ADDR;
      iq_flush_r        <= `MO_RST_BIT;
      refetch_r         <= `MO_RST_BIT;
      sq_no_gather_r    <= `MO_RST_BIT;
      bus_req_valid_r   <= `MO_RST_BIT;
      bus_req_kind_r    <= mem_order_pkg::k_none;
      bus_req_addr_r    <= `MO_RST_ADDR;
      bus_l2_bypass_r   <= `MO_RST_BIT;
      snoop_zero_r      <= `MO_RST_BIT;
      snoop_zero_addr_r <= `MO_RST_ADDR;
    end else if (ce) begin
      state_r           <= state_nxt;
      cur_kind_r        <= cur_kind_nxt;
      cur_addr_r        <= cur_addr_nxt;
      bcast_en_s_r      <= bcast_en_s_nxt;
      op_ready_r        <= op_ready_nxt;
      op_done_r         <= op_done_nxt;
      ci_issue_r        <= ci_issue_nxt;
      cache_op_valid_r  <= cache_op_valid_nxt;
      cache_op_kind_r   <= cache_op_kind_nxt;
      cache_op_addr_r   <= cache_op_addr_nxt;
      iq_flush_r        <= iq_flush_nxt;
      refetch_r         <= refetch_nxt;
      sq_no_gather_r    <= sq_no_gather_nxt;
      bus_req_valid_r   <= bus_req_valid_nxt;
      bus_req_kind_r    <= bus_req_kind_nxt;
      bus_req_addr_r    <= bus_req_addr_nxt;
      bus_l2_bypass_r   <= bus_l2_bypass_nxt;
      snoop_zero_r      <= snoop_zero_nxt;
      snoop_zero_addr_r <= snoop_zero_addr_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  eieio_waits_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && state_r == mem_order_pkg::st_wait_ciwt && ciwt_pending |=> state_r == mem_order_pkg::st_wait_ciwt)
    else $error("barrier left wait while accesses pending");
  ci_held_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ci_issue_r |-> !sq_no_gather_r && state_r == mem_order_pkg::st_idle)
    else $error("access issued during barrier");
  eieio_bcast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && state_r == mem_order_pkg::st_wait_ciwt && !ciwt_pending && bcast_en_s_r |=> bus_req_valid_r)
    else $error("barrier not broadcast");
  eieio_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus_req_valid_r && bus_req_kind_r == mem_order_pkg::k_eieio |-> bus_l2_bypass_r)
    else $error("barrier not routed around l2");
  eieio_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && state_r == mem_order_pkg::st_wait_ciwt && !bcast_en_s_r |=> !bus_req_valid_r)
    else $error("barrier broadcast while disabled");
  no_gather_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r != mem_order_pkg::st_idle && cur_kind_r == mem_order_pkg::k_eieio |-> sq_no_gather_r)
    else $error("gathering allowed across barrier");
  isync_refetch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(refetch_r) |-> $past(!older_busy && !older_exc_window) && op_done_r)
    else $error("refetch before older instructions settled");
  isync_flush_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take && op_kind == mem_order_pkg::k_isync |=> iq_flush_r && !refetch_r)
    else $error("queue not flushed on refetch barrier");
  zero_bcast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take && op_kind == mem_order_pkg::k_dcbz && op_coh && !op_seg_t |=> bus_req_valid_r)
    else $error("coherent zero op not broadcast");
  gated_bcast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take && !address_broadcast_enable && (op_kind == mem_order_pkg::k_dcbf ||
    op_kind == mem_order_pkg::k_dcbi || op_kind == mem_order_pkg::k_dcbst) |=> !bus_req_valid_r)
    else $error("cache op broadcast while disabled");
  no_icbi_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus_req_valid_r |-> bus_req_kind_r != mem_order_pkg::k_icbi)
    else $error("instruction invalidate on bus");
  snoop_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && snoop_valid |=> snoop_zero_r == ($past(snoop_kind) == mem_order_pkg::k_dcbz))
    else $error("wrong snoop response");
  tseg_nop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take && op_seg_t && is_cache_op(op_kind) |=> op_done_r && !cache_op_valid_r && !bus_req_valid_r)
    else $error("direct-store cache op not ignored");
  sync_done_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(op_done_r) && cur_kind_r == mem_order_pkg::k_sync && bcast_en_s_r |-> $past(bus_ack))
    else $error("full barrier done before broadcast");
  in_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && !op_ready_r |=> !ci_issue_r)
    else $error("access released while busy");
  isync_no_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && state_r == mem_order_pkg::st_isync && !older_busy && !older_exc_window |=> refetch_r)
    else $error("refetch barrier stalled");
  cache_local_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take && is_cache_op(op_kind) && !op_seg_t |=> cache_op_valid_r && cache_op_kind_r == $past(op_kind))
    else $error("cache op not applied locally");
  bcast_sample_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && take |=> bcast_en_s_r == $past(address_broadcast_enable))
    else $error("broadcast enable not sampled at take");

endmodule

/* File: tb/bus_unit_model.sv */
// ------------------------------------------------------------
// bus unit stand-in: acks each broadcast ack_delay+1 cycles after bus_req_valid_r rises
// ------------------------------------------------------------
// assumes bus_req_valid_r holds until the edge after bus_ack
`timescale 1ns/1ns
module bus_unit_model (
  // clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // broadcast handshake
  input  wire logic       bus_req_valid_r,
  input  wire logic [3:0] ack_delay,
  output logic            bus_ack
);
  logic [3:0] wait_r;
  // ack is held until an edge with ce high takes it, a dropped ack would hang the op
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      wait_r  <= 4'h0;
    end else if (ce) begin
      if (bus_ack || !bus_req_valid_r) begin
        bus_ack <= 1'b0;
        wait_r  <= 4'h0;
      end else if (wait_r >= ack_delay) begin
        bus_ack <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// ------------------------------------------------------------
// self-checking bench for the ordering and broadcast sequencer
// ------------------------------------------------------------
// assumes bus_unit_model on the far side; inputs change at falling edges
`timescale 1ns/1ns
module testbench;
  typedef mem_order_pkg::op_kind_e kind_t;
  typedef struct {kind_t kind; logic [31:0] addr; logic [4:0] fl;} exp_s;
  logic        core_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, address_broadcast_enable = 1'b0;
  logic        op_valid = 1'b0, op_coh = 1'b0, op_seg_t = 1'b0, snoop_valid = 1'b0;
  logic        ciwt_pending = 1'b0, older_busy = 1'b0, older_exc_window = 1'b0;
  kind_t       op_kind = mem_order_pkg::k_none, snoop_kind = mem_order_pkg::k_none;
  logic [31:0] op_addr = 32'h0, snoop_addr = 32'h0;
  logic [3:0]  ack_delay = 4'h0;
  logic        op_ready_r, op_done_r, ci_issue_r, cache_op_valid_r, iq_flush_r, refetch_r;
  logic        sq_no_gather_r, bus_req_valid_r, bus_l2_bypass_r, bus_ack, snoop_zero_r, b, t;
  kind_t       cache_op_kind_r, bus_req_kind_r, k;
  logic [31:0] cache_op_addr_r, bus_req_addr_r, snoop_zero_addr_r;
  logic [15:0] lfsr_r = 16'h714f, r;
  logic [4:0]  seen = 5'h0;
  exp_s        exp_q[$];
  logic [31:0] snoop_q[$];
  int          fails = 0, n_compared = 0, i;

  always #25 core_clk = ~core_clk;

  memory_ordering_cache_op_broadcast memory_ordering_cache_op_broadcast_i (
    .core_clk, .rst_b, .ce, .address_broadcast_enable, .op_valid, .op_kind, .op_addr, .op_coh,
    .op_seg_t, .op_ready_r, .op_done_r, .ci_issue_r, .ciwt_pending, .older_busy, .older_exc_window,
    .cache_op_valid_r, .cache_op_kind_r, .cache_op_addr_r, .iq_flush_r, .refetch_r, .sq_no_gather_r,
    .bus_req_valid_r, .bus_req_kind_r, .bus_req_addr_r, .bus_l2_bypass_r, .bus_ack, .snoop_valid,
    .snoop_kind, .snoop_addr, .snoop_zero_r, .snoop_zero_addr_r);
  bus_unit_model bus_unit_model_i (.core_clk, .rst_b, .ce, .bus_req_valid_r, .ack_delay, .bus_ack);

  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction
  task automatic end_sim();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_op(exp_s e, logic [4:0] g);
    n_compared++;
    if (g !== e.fl) begin
      fails++;
      $display("wrong value op %s expected %b seen %b", e.kind.name(), e.fl, g);
    end
  endtask
  // fl is {bus, cache op, queue flush, inhibited issue, no gather}
  task automatic issue(kind_t kd, logic [31:0] a, logic c, logic s, logic [4:0] fl, logic last);
    int n;
    exp_q.push_back('{kd, a, fl});
    op_kind = kd;
    op_addr = a;
    op_coh = c;
    op_seg_t = s;
    op_valid = 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk);
      if (ce && op_ready_r) break;
    end
    if (n == 400) begin
      fails++;
      end_sim();
    end
    @(negedge core_clk);
    if (last) op_valid = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400 && !(op_ready_r === 1'b1 && exp_q.size() == 0); n++) @(negedge core_clk);
    if (n == 400) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic hold_check(string nm);
    repeat (4) @(negedge core_clk);
    chk(nm, 32'h0, 32'(op_ready_r));
  endtask

  // ------------------------------------------------------------
  // monitor: bus and cache results are checked against the oldest note; done and snoop results take it off its queue
  // ------------------------------------------------------------
  // sampled on enabled edges only, so a pulse stretched by ce low counts once
  always @(posedge core_clk) begin
    if (rst_b && ce) begin
      seen = seen | {bus_req_valid_r, cache_op_valid_r, iq_flush_r, ci_issue_r, sq_no_gather_r};
      if (exp_q.size() > 0 && bus_req_valid_r) begin
        chk("bus kind", 32'(exp_q[0].kind), 32'(bus_req_kind_r));
        chk("l2 bypass", 32'(exp_q[0].kind == mem_order_pkg::k_eieio), 32'(bus_l2_bypass_r));
        if (exp_q[0].kind > mem_order_pkg::k_sync) chk("bus addr", exp_q[0].addr, bus_req_addr_r);
      end
      if (exp_q.size() > 0 && cache_op_valid_r) begin
        chk("cache kind", 32'(exp_q[0].kind), 32'(cache_op_kind_r));
        chk("cache addr", exp_q[0].addr, cache_op_addr_r);
      end
      if (op_done_r) begin
        if (exp_q.size() == 0) begin
          chk("stray done", 32'h0, 32'h1);
        end else begin
          chk("refetch", 32'(exp_q[0].kind == mem_order_pkg::k_isync), 32'(refetch_r));
          chk_op(exp_q.pop_front(), seen);
        end
        seen = 5'h0;
      end
      if (snoop_zero_r) begin
        if (snoop_q.size() == 0) chk("stray snoop", 32'h0, 32'h1);
        else chk("snoop addr", snoop_q.pop_front(), snoop_zero_addr_r);
      end
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    chk("ready at reset", 32'h1, 32'(op_ready_r));
    for (i = 0; i < 3; i++) issue(mem_order_pkg::k_ci_access, {rnd(), rnd()}, 1'b0, 1'b0, 5'h02, i == 2);
    issue(mem_order_pkg::k_none, 32'h0, 1'b0, 1'b0, 5'h00, 1'b1);
    wait_idle();
    for (i = 0; i < 2; i++) begin
      address_broadcast_enable = i[0];
      ack_delay = 4'(i * 5);
      ciwt_pending = 1'b1;
      issue(mem_order_pkg::k_eieio, 32'h0, 1'b0, 1'b0, {i[0], 4'h1}, 1'b0);
      fork
        issue(mem_order_pkg::k_ci_access, 32'h0, 1'b0, 1'b0, 5'h02, 1'b1);
        begin
          address_broadcast_enable = !i[0];
          hold_check("eieio held");
          ciwt_pending = 1'b0;
        end
      join
      wait_idle();
      address_broadcast_enable = i[0];
      older_busy = 1'b1;
      ciwt_pending = 1'b1;
      issue(mem_order_pkg::k_sync, 32'h0, 1'b0, 1'b0, {i[0], 4'h1}, 1'b1);
      hold_check("sync older");
      older_busy = 1'b0;
      hold_check("sync ciwt");
      ciwt_pending = 1'b0;
      wait_idle();
    end
    // pending inhibited accesses stand in for queued stores: the refetch must not wait on them
    ciwt_pending = 1'b1;
    older_busy = 1'b1;
    older_exc_window = 1'b1;
    issue(mem_order_pkg::k_isync, 32'h0, 1'b0, 1'b0, 5'h04, 1'b1);
    hold_check("isync older");
    older_busy = 1'b0;
    hold_check("isync exc");
    older_exc_window = 1'b0;
    wait_idle();
    ciwt_pending = 1'b0;
    for (i = 0; i < 60; i++) begin
      r = rnd();
      k = kind_t'(4'h5 + 4'(r % 5));
      t = r[7] & r[8];
      b = t ? 1'b0 : (k == mem_order_pkg::k_dcbz ? r[6] : (k == mem_order_pkg::k_icbi ? 1'b0 : r[5]));
      address_broadcast_enable = r[5];
      ack_delay = {1'b0, r[11:9]};
      issue(k, {rnd(), rnd()}, r[6], t, {b, !t, 3'h0}, 1'b1);
      address_broadcast_enable = ~r[5];
      ce = 1'b0;
      repeat (1 + r[13:12]) @(negedge core_clk);
      ce = 1'b1;
      wait_idle();
    end
    for (i = 0; i < 40; i++) begin
      r = rnd();
      snoop_valid = r[0] | r[1];
      snoop_kind = r[2] ? mem_order_pkg::k_dcbz : kind_t'(4'(r % 10));
      snoop_addr = {rnd(), rnd()};
      address_broadcast_enable = r[4];
      if (snoop_valid && snoop_kind == mem_order_pkg::k_dcbz) snoop_q.push_back(snoop_addr);
      @(negedge core_clk);
    end
    snoop_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("open ops", 32'h0, 32'(exp_q.size()));
    chk("open snoops", 32'h0, 32'(snoop_q.size()));
    end_sim();
  end
endmodule
